//--- inc/pio_pkg.sv
package pio_pkg;
    // geometry: eight ports of eight bit positions each
    localparam int NPORT = 8;
    localparam int PW = 8;
    localparam int NPIN = 64;
    localparam int AW = 16;
    localparam int DW = 8;
    // register addresses
    localparam logic [15:0] DATA_BASE = 16'h0000;
    localparam logic [15:0] OE_BASE = 16'h30B0;
    localparam logic [15:0] IE_BASE = 16'h30B8;
    localparam logic [15:0] FLT0_ADDR = 16'h30EC;
    localparam logic [15:0] FLT1_ADDR = 16'h30ED;
    localparam logic [15:0] FLT2_ADDR = 16'h30EE;
    localparam logic [15:0] FDIV_ADDR = 16'h30EF;
    localparam logic [15:0] PE_BASE = 16'h30F0;
    localparam logic [15:0] SYSREL_ADDR = 16'h30E0;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [63:0] RST_WORD = 64'h0000_0000_0000_0000;
    // bonded pins: A..F full, G[3:0], H[7:6] and H[2:0]
    localparam logic [63:0] PIN_PRESENT_DEF = 64'hC70F_FFFF_FFFF_FFFF;
    // pins owned by system functions out of reset
    localparam int SYS_DBG_PIN = 4;
    localparam int SYS_RST_PIN = 5;
    // divider register fields
    localparam int DIV_SEL_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 4;
    localparam logic [3:0] BUS_DIV_MAX = 4'hC;
    localparam logic [3:0] LPO_DIV_MAX = 4'h7;
    // filter field width, ports per filter register
    localparam int FLT_W = 2;
    localparam int PORTS_PER_FLT = 4;
    localparam int PRE_W = 12;
    localparam logic [1:0] FLT_OFF = 2'h0;

    // override lines from peripherals and analog blocks
    typedef struct packed {
        logic [63:0] owned;
        logic [63:0] drive;
        logic [63:0] level;
        logic [63:0] analog;
    } pio_ovr_t;

    // per-pin pad controls
    typedef struct packed {
        logic [63:0] out;
        logic [63:0] oe;
        logic [63:0] pull;
        logic [63:0] in_en;
    } pio_pad_t;
endpackage : pio_pkg

//--- design/pio_port.sv
// Behaviour
// - eight ports, per-pin data, ie, oe, pullup
// - enabled peripheral takes over its pin
// - reset: port owns pins except two system
// - reset: pins hi-z, enables cleared
// - read: ie gives pin, else latch
// - oe and ie both set: read latch
// - port direction bits pick read source unless analog
// - analog owns pin: digital off, reads 0
// - analog beats alternate digital function
// - pullup enable bit turns pullup on
// - pullup off while pin drives output
// - pullup off under analog control
// - every digital input passes glitch filter
// - threshold programmable via select and divider
// - one filter field per whole port
// - deep stop keeps all state
// - data write stores bonded bits only, drives outputs
// - reset clears data registers
`timescale 1ns/10ps
`default_nettype none
module pio_port
    import pio_pkg::*;
#(
    parameter logic [63:0] PIN_PRESENT = PIN_PRESENT_DEF
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DW-1:0] rdata,
    input wire pio_ovr_t ovr,
    input wire logic [NPIN-1:0] pin_level,
    input wire logic lpo_tick,
    input wire logic deep_stop,
    output pio_pad_t pad,
    output logic [NPIN-1:0] filt_in
);
    // software-visible state: one bit per pin, then filter, divider and release registers
    logic [NPIN-1:0] data_r, data_nxt; // pin_data_latch
    logic [NPIN-1:0] oe_r, oe_nxt; // pin_output_enable
    logic [NPIN-1:0] ie_r, ie_nxt; // pin_input_enable
    logic [NPIN-1:0] pe_r, pe_nxt; // pin_pullup_enable
    logic [DW-1:0] flt0_r, flt0_nxt; // glitch_filter_select, ports a..d
    logic [DW-1:0] flt1_r, flt1_nxt; // glitch_filter_select, ports e..h
    logic [DW-1:0] flt2_r, flt2_nxt; // spare filter register
    logic [DW-1:0] fdiv_r, fdiv_nxt; // filter_clock_divider
    logic [1:0] sysrel_r, sysrel_nxt; // release of system pins to the port
    logic [DW-1:0] rdata_nxt;
    logic [NPIN-1:0] rd_val; // data read view of every pin
    // filter time base
    logic [PRE_W-1:0] presc_r, presc_nxt;
    logic [PRE_W-1:0] presc_lim;
    logic [DIV_W-1:0] div_eff;
    logic flt_tick;
    // filter state
    logic [NPIN-1:0] filt_r, filt_nxt;
    logic [FLT_W-1:0] cnt_r [NPIN];
    logic [FLT_W-1:0] cnt_nxt [NPIN];
    logic [FLT_W-1:0] thr [NPORT];
    // pad control
    pio_pad_t pad_nxt;
    logic [NPIN-1:0] sys_own; // still held by debug/reset functions
    logic [NPIN-1:0] periph; // alternate digital owner active
    logic [NPIN-1:0] drv; // pin driven by anyone

    // read view: analog reads zero, ie without oe reads pin, else latch
    always_comb begin
        rd_val = RST_WORD; // every bit is overwritten below
        for (int i = 0; i < NPIN; i++) begin
            if (ovr.analog[i]) begin
                rd_val[i] = 1'b0;
            end else if (ie_r[i] && !oe_r[i]) begin
                rd_val[i] = filt_r[i];
            end else begin
                rd_val[i] = data_r[i];
            end
        end
        rd_val = rd_val & PIN_PRESENT;
    end

    // register file next values and read data
    always_comb begin
        data_nxt = data_r;
        oe_nxt = oe_r;
        ie_nxt = ie_r;
        pe_nxt = pe_r;
        flt0_nxt = flt0_r;
        flt1_nxt = flt1_r;
        flt2_nxt = flt2_r;
        fdiv_nxt = fdiv_r;
        sysrel_nxt = sysrel_r;
        rdata_nxt = RST_BYTE; // data valid only in the cycle after a read
        for (int p = 0; p < NPORT; p++) begin
            if (wr_en) begin
                // absent pins stay zero so reads never show phantom bits
                if (addr == DATA_BASE + 16'(p)) begin
                    data_nxt[p*PW +: PW] = wdata & PIN_PRESENT[p*PW +: PW];
                end
                if (addr == OE_BASE + 16'(p)) begin
                    oe_nxt[p*PW +: PW] = wdata & PIN_PRESENT[p*PW +: PW];
                end
                if (addr == IE_BASE + 16'(p)) begin
                    ie_nxt[p*PW +: PW] = wdata & PIN_PRESENT[p*PW +: PW];
                end
                if (addr == PE_BASE + 16'(p)) begin
                    pe_nxt[p*PW +: PW] = wdata & PIN_PRESENT[p*PW +: PW];
                end
            end
            if (rd_en) begin
                if (addr == DATA_BASE + 16'(p)) begin
                    rdata_nxt = rd_val[p*PW +: PW];
                end
                if (addr == OE_BASE + 16'(p)) begin
                    rdata_nxt = oe_r[p*PW +: PW];
                end
                if (addr == IE_BASE + 16'(p)) begin
                    rdata_nxt = ie_r[p*PW +: PW];
                end
                if (addr == PE_BASE + 16'(p)) begin
                    rdata_nxt = pe_r[p*PW +: PW];
                end
            end
        end
        if (wr_en) begin
            unique case (addr)
                FLT0_ADDR: flt0_nxt = wdata;
                FLT1_ADDR: flt1_nxt = wdata;
                FLT2_ADDR: flt2_nxt = wdata;
                FDIV_ADDR: fdiv_nxt = wdata;
                SYSREL_ADDR: sysrel_nxt = wdata[1:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                FLT0_ADDR: rdata_nxt = flt0_r;
                FLT1_ADDR: rdata_nxt = flt1_r;
                FLT2_ADDR: rdata_nxt = flt2_r;
                FDIV_ADDR: rdata_nxt = fdiv_r;
                SYSREL_ADDR: rdata_nxt = {6'h00, sysrel_r};
                default: ; // unmapped reads return zero
            endcase
        end
    end

    // register file flops; deep stop needs no gating, state simply holds
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_r <= RST_WORD;
            oe_r <= RST_WORD;
            ie_r <= RST_WORD;
            pe_r <= RST_WORD;
            flt0_r <= RST_BYTE;
            flt1_r <= RST_BYTE;
            flt2_r <= RST_BYTE;
            fdiv_r <= RST_BYTE;
            sysrel_r <= 2'h0;
            rdata <= RST_BYTE;
        end else begin
            data_r <= data_nxt;
            oe_r <= oe_nxt;
            ie_r <= ie_nxt;
            pe_r <= pe_nxt;
            flt0_r <= flt0_nxt;
            flt1_r <= flt1_nxt;
            flt2_r <= flt2_nxt;
            fdiv_r <= fdiv_nxt;
            sysrel_r <= sysrel_nxt;
            rdata <= rdata_nxt;
        end
    end

    // filter time base: bus clock or low-power ticks, divided by 2^n
    always_comb begin
        div_eff = fdiv_r[DIV_LSB +: DIV_W];
        // clamp so the longest tick stays at 4096 bus or 128 lpo clocks
        if (fdiv_r[DIV_SEL_BIT] && div_eff > LPO_DIV_MAX) begin
            div_eff = LPO_DIV_MAX;
        end else if (!fdiv_r[DIV_SEL_BIT] && div_eff > BUS_DIV_MAX) begin
            div_eff = BUS_DIV_MAX;
        end
        presc_lim = PRE_W'((13'h0001 << div_eff) - 13'h0001);
        presc_nxt = presc_r;
        flt_tick = 1'b0;
        if (deep_stop) begin
            presc_nxt = presc_r;
        end else if (!fdiv_r[DIV_SEL_BIT] || lpo_tick) begin
            if (presc_r >= presc_lim) begin
                presc_nxt = '0;
                flt_tick = 1'b1;
            end else begin
                presc_nxt = presc_r + PRE_W'(1);
            end
        end
    end

    // time base flop
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // one threshold per port, shared by its eight pins
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            if (p < PORTS_PER_FLT) begin
                thr[p] = flt0_r[p*FLT_W +: FLT_W];
            end else begin
                thr[p] = flt1_r[(p-PORTS_PER_FLT)*FLT_W +: FLT_W];
            end
        end
    end

    // per-pin glitch filter
    for (genvar g = 0; g < NPIN; g++) begin : g_flt
        always_comb begin
            cnt_nxt[g] = cnt_r[g];
            filt_nxt[g] = filt_r[g];
            if (deep_stop) begin
                cnt_nxt[g] = cnt_r[g];
            end else if (thr[g/PW] == FLT_OFF) begin
                filt_nxt[g] = pin_level[g]; // bypass, raw level passes
                cnt_nxt[g] = '0;
            end else if (pin_level[g] == filt_r[g]) begin
                cnt_nxt[g] = '0; // short pulse discarded
            end else if (flt_tick) begin
                if (cnt_r[g] + FLT_W'(1) >= thr[g/PW]) begin
                    filt_nxt[g] = pin_level[g];
                    cnt_nxt[g] = '0;
                end else begin
                    cnt_nxt[g] = cnt_r[g] + FLT_W'(1);
                end
            end
        end

        // filter flops
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                cnt_r[g] <= '0;
                filt_r[g] <= 1'b0;
            end else begin
                cnt_r[g] <= cnt_nxt[g];
                filt_r[g] <= filt_nxt[g];
            end
        end
    end

    // pad control: analog over peripheral over port
    always_comb begin
        sys_own = RST_WORD;
        sys_own[SYS_DBG_PIN] = !sysrel_r[0];
        sys_own[SYS_RST_PIN] = !sysrel_r[1];
        periph = (ovr.owned | sys_own) & ~ovr.analog & PIN_PRESENT;
        drv = ~ovr.analog & ((periph & ovr.drive) | (~periph & oe_r));
        pad_nxt.oe = drv & PIN_PRESENT;
        pad_nxt.out = (periph & ovr.level) | (~periph & data_r);
        pad_nxt.in_en = ~ovr.analog & (periph | ie_r) & PIN_PRESENT;
        pad_nxt.pull = pe_r & ~drv & ~ovr.analog & PIN_PRESENT;
    end

    // pad and filtered input flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pad <= '0;
            filt_in <= RST_WORD;
        end else begin
            pad <= pad_nxt;
            filt_in <= filt_r & PIN_PRESENT;
        end
    end
endmodule : pio_port
`default_nettype wire

//--- tb/pio_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
// boundary checks on read path and pad overrides
module pio_port_properties
    import pio_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DW-1:0] rdata,
    input wire pio_ovr_t ovr,
    input wire pio_pad_t pad
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // pads lag their cause by one edge, hence the past on causes
    a_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("rdata not idle");
    a_pull_out: assert property ((pad.pull & pad.oe) == 64'h0)
        else $error("pull while driving");
    a_analog_off: assert property ($past(reset_n) |->
        ($past(ovr.analog) & (pad.oe | pad.pull | pad.in_en)) == 64'h0)
        else $error("analog pin active");
    a_own_dir: assert property ($past(reset_n) |->
        ($past(ovr.owned & ~ovr.analog) & (pad.oe ^ $past(ovr.drive))) == 64'h0)
        else $error("owned pin direction");
    a_own_level: assert property ($past(reset_n) |->
        ($past(ovr.owned & ovr.drive & ~ovr.analog) & (pad.out ^ $past(ovr.level))) == 64'h0)
        else $error("owned pin level");
    a_own_input: assert property ($past(reset_n) |->
        ($past(ovr.owned & ~ovr.analog) & ~pad.in_en) == 64'h0)
        else $error("owned pin input off");
    a_rd_analog: assert property (rd_en && addr == 16'h0001 |=>
        (rdata & $past(ovr.analog[15:8])) == 8'h00) else $error("analog bit read");
    // a write or override change just before would leave the pad one edge stale
    a_rd_latch: assert property (rd_en && addr == 16'h0001 && !$past(wr_en)
        && $stable(ovr) |=>
        ((rdata ^ $past(pad.out[15:8])) & $past(pad.oe[15:8] & ~ovr.owned[15:8])) == 8'h00)
        else $error("driven bit read");
    c_rd: cover property (rd_en && addr == 16'h0001);
    c_own: cover property (|(ovr.owned & ovr.drive));
    c_analog: cover property (|ovr.analog);
endmodule : pio_port_properties
bind pio_port pio_port_properties u_props (.clock, .reset_n, .addr, .wr_en, .rd_en,
    .rdata, .ovr, .pad);
`default_nettype wire

//--- tb/pio_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
// board side: pad driver, external source, pull-up or a wandering float
module pio_pad_model
    import pio_pkg::*;
(
    input wire logic clock,
    input wire pio_pad_t pad,
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_val,
    output logic [NPIN-1:0] pin_level
);
    // floating pins flip every cycle so a stale level never looks valid
    logic [NPIN-1:0] float_r = 64'h6A6A_6A6A_6A6A_6A6A;
    always @(posedge clock) begin
        float_r <= ~float_r;
    end
    always_comb begin
        pin_level = pad.oe & pad.out;
        pin_level |= ~pad.oe & ext_en & ext_val;
        pin_level |= ~pad.oe & ~ext_en & (pad.pull | float_r);
    end
endmodule : pio_pad_model
`default_nettype wire

//--- tb/pio_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
// counts every compare, reports each mismatch
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module pio_port_bench import pio_pkg::*;;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [AW-1:0] addr = 16'h0000;
    logic [DW-1:0] wdata = 8'h00;
    logic wr_en = 1'b0, rd_en = 1'b0, lpo_tick = 1'b0, deep_stop = 1'b0;
    logic [NPIN-1:0] ext_en = 64'h0, ext_val = 64'h0;
    logic [DW-1:0] rdata;
    logic [NPIN-1:0] pin_level, filt_in;
    pio_ovr_t ovr = 256'h0;
    pio_pad_t pad;
    int fails = 0, samples_checked = 0, cyc = 0;
    pio_port u_dut (.clock, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .ovr,
        .pin_level, .lpo_tick, .deep_stop, .pad, .filt_in);
    pio_pad_model u_pins (.clock, .pad, .ext_en, .ext_val, .pin_level);
    initial begin
        forever #20 clock = ~clock;
    end
    // low-power tick every eighth clock; ceiling far above the run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        lpo_tick <= (cyc[2:0] == 3'h7);
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wt
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    // answer stands one cycle only: sample mid-cycle, return on a rising edge
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        `CHK("rdata", e, rdata)
        @(posedge clock);
    endtask : rd
    task automatic t_reset();
        `CHK("oe", 64'h0, pad.oe)
        `CHK("in_en", 64'h30, pad.in_en)
        for (int p = 0; p < 8; p++) begin
            rd(DATA_BASE + 16'(p), 8'h00);
            rd(OE_BASE + 16'(p), 8'h00);
            rd(IE_BASE + 16'(p), 8'h00);
            rd(PE_BASE + 16'(p), 8'h00);
            if (p < 4) rd(FLT0_ADDR + 16'(p), 8'h00);
        end
        rd(16'h30E1, 8'h00);
    endtask : t_reset
    task automatic t_out();
        wr(DATA_BASE + 16'h1, 8'hA5);
        wr(OE_BASE + 16'h1, 8'hFF);
        wr(PE_BASE + 16'h1, 8'hFF);
        wt(2);
        `CHK("out_b", 8'hA5, pad.out[15:8])
        `CHK("pull_b", 8'h00, pad.pull[15:8])
        rd(DATA_BASE + 16'h1, 8'hA5);
    endtask : t_out
    task automatic t_in();
        wr(IE_BASE + 16'h2, 8'hFF);
        wr(PE_BASE + 16'h2, 8'h0F);
        ext_en[23:16] <= 8'hF0;
        ext_val[23:16] <= 8'h30;
        wt(4);
        `CHK("pull_c", 8'h0F, pad.pull[23:16])
        `CHK("filt_c", 8'h3F, filt_in[23:16])
        rd(DATA_BASE + 16'h2, 8'h3F);
        wr(IE_BASE + 16'h2, 8'h00);
        rd(DATA_BASE + 16'h2, 8'h00);
    endtask : t_in
    task automatic t_periph();
        wr(DATA_BASE + 16'h3, 8'hC3);
        wr(OE_BASE + 16'h3, 8'hFF);
        wr(IE_BASE + 16'h3, 8'hFF);
        wr(PE_BASE + 16'h3, 8'hFF);
        ovr.owned[31:24] <= 8'hFF;
        ovr.drive[31:24] <= 8'hF0;
        ovr.level[31:24] <= 8'h5A;
        wt(3);
        `CHK("oe_d", 8'hF0, pad.oe[31:24])
        `CHK("pull_d", 8'h0F, pad.pull[31:24])
        rd(DATA_BASE + 16'h3, 8'hC3);
        wr(OE_BASE + 16'h3, 8'h00);
        rd(DATA_BASE + 16'h3, 8'h5F);
        ovr.owned[31:24] <= 8'h00;
    endtask : t_periph
    task automatic t_analog();
        ovr.analog[15:8] <= 8'h0F;
        ovr.owned[15:8] <= 8'h0F;
        ovr.drive[15:8] <= 8'h0F;
        wt(3);
        `CHK("oe_b", 8'hF0, pad.oe[15:8])
        `CHK("pull_b", 8'h00, pad.pull[15:8])
        rd(DATA_BASE + 16'h1, 8'hA0);
        ovr <= 256'h0;
    endtask : t_analog
    task automatic t_sys();
        ovr.drive[5:4] <= 2'h3;
        ovr.level[5:4] <= 2'h1;
        wt(3);
        `CHK("oe_sys", 2'h3, pad.oe[5:4])
        `CHK("out_sys", 2'h1, pad.out[5:4])
        wr(SYSREL_ADDR, 8'h03);
        wt(2);
        `CHK("oe_rel", 2'h0, pad.oe[5:4])
        ovr <= 256'h0;
    endtask : t_sys
    // field 3 at four clocks a tick: twelve clocks to pass
    task automatic t_filter();
        wr(FDIV_ADDR, 8'h02);
        wr(FLT1_ADDR, 8'h03);
        ext_en[39:32] <= 8'hFF;
        wt(40);
        ext_val[39:32] <= 8'hFF;
        wt(4);
        ext_val[39:32] <= 8'h00;
        for (int i = 0; i < 30; i++) begin
            wt(1);
            `CHK("glitch_e", 8'h00, filt_in[39:32])
        end
        ext_val[39:32] <= 8'hFF;
        wt(6);
        `CHK("early_e", 8'h00, filt_in[39:32])
        wt(40);
        `CHK("late_e", 8'hFF, filt_in[39:32])
        // low-power source, one tick per eight clocks: three ticks needed
        wr(FDIV_ADDR, 8'h80);
        ext_val[39:32] <= 8'h00;
        wt(14);
        `CHK("lpo_early", 8'hFF, filt_in[39:32])
        wt(20);
        `CHK("lpo_late", 8'h00, filt_in[39:32])
    endtask : t_filter
    // filter must freeze in deep stop and resume after it
    task automatic t_stop();
        deep_stop <= 1'b1;
        ext_val[39:32] <= 8'hFF;
        wt(40);
        `CHK("out_stop", 8'hA5, pad.out[15:8])
        `CHK("filt_stop", 8'h00, filt_in[39:32])
        deep_stop <= 1'b0;
        rd(DATA_BASE + 16'h1, 8'hA5);
        wt(40);
        `CHK("filt_wake", 8'hFF, filt_in[39:32])
    endtask : t_stop
    // second reset in mid-run must restore pad enables, port b data and the filter select
    task automatic t_rerun();
        reset_n <= 1'b0;
        wt(2);
        reset_n <= 1'b1;
        wt(2);
        `CHK("oe_rst", 64'h0, pad.oe)
        `CHK("in_en_rst", 64'h30, pad.in_en)
        rd(DATA_BASE + 16'h1, 8'h00);
        rd(FLT1_ADDR, 8'h00);
    endtask : t_rerun
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        wt(2);
        t_reset();
        t_out();
        t_in();
        t_periph();
        t_analog();
        t_sys();
        t_filter();
        t_stop();
        t_rerun();
        print_verdict();
    end
endmodule : pio_port_bench
`default_nettype wire
